// *** qiu_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module qiu_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // memory port
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memProbe,
    input wire logic memLock,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic memErr,
    output logic [31:0] memRdata,
    // behaviour control
    input wire logic slow,
    input wire logic [31:0] faultAddr
);
    // plain always: the bench preloads words by backdoor
    logic [31:0] mem [0:127];
    logic [1:0] cnt_r;
    logic ack_r;
    logic err_r;
    logic [31:0] last_r;
    wire hit = memReq && !ack_r && (cnt_r == (slow ? 2'h3 : 2'h0));
    wire bad = memAddr == faultAddr;
    assign memAck = ack_r;
    assign memErr = ack_r & err_r;
    // data line shows garbage outside the ack cycle
    assign memRdata = ack_r ? last_r : ~last_r;
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            cnt_r <= 2'h0;
            last_r <= 32'h0;
        end else begin
            ack_r <= hit;
            cnt_r <= (memReq && !ack_r && !hit) ? cnt_r + 2'h1 : 2'h0;
            if (hit) begin
                err_r <= bad;
                last_r <= mem[memAddr[8:2]];
            end
        end
    end
    // writes land only for acked non-probe requests off faultAddr; memLock is ignored
    always @(posedge core_clk) begin
        if (hit && memWrite && !memProbe && !bad) begin
            mem[memAddr[8:2]] <= memWdata;
        end
    end
endmodule : qiu_mem_model
`default_nettype wire

// *** qiu_pkg.sv ***
package qiu_pkg;

    // register byte offsets
    localparam logic [7:0] QIU_CTRL_OFF = 8'h00;
    localparam logic [7:0] QIU_OPA_OFF = 8'h04;
    localparam logic [7:0] QIU_OPB_OFF = 8'h08;
    localparam logic [7:0] QIU_STATUS_OFF = 8'h0c;
    localparam logic [7:0] QIU_IRQ_STAT_OFF = 8'h10;
    localparam logic [7:0] QIU_IRQ_MASK_OFF = 8'h14;
    localparam logic [7:0] QIU_RESULT_OFF = 8'h18;

    // control and status fields
    localparam int QIU_CTRL_START_BIT = 0;
    localparam int QIU_CTRL_OPC_LSB = 8;
    localparam int QIU_STATUS_BUSY_BIT = 8;

    // interrupt status bits
    localparam int QIU_IRQ_DONE_BIT = 0;
    localparam int QIU_IRQ_RSVOP_BIT = 1;
    localparam int QIU_IRQ_MMF_BIT = 2;
    localparam int QIU_IRQ_W = 3;

    // opcodes
    localparam logic [7:0] QIU_OPC_INSERT_TAIL_LOCKED = 8'h5d;
    localparam logic [7:0] QIU_OPC_REMOVE_HEAD_LOCKED = 8'h5e;
    localparam logic [7:0] QIU_OPC_INSERT_AFTER_PRED = 8'h0e;

    // link layout
    localparam logic [31:0] QIU_BACK_LINK_OFF = 32'h0000_0004;
    localparam logic [31:0] QIU_LOCK_MASK = 32'h0000_0001;
    localparam logic [31:0] QIU_ZERO_WORD = 32'h0000_0000;

    // reset values
    localparam logic [31:0] QIU_WORD_RST = 32'h0000_0000;
    localparam logic [3:0] QIU_FLAGS_RST = 4'h0;
    localparam logic [QIU_IRQ_W-1:0] QIU_IRQ_RST = 3'h0;
    localparam logic [2:0] QIU_STEP_RST = 3'h0;

    // condition flag words, order N Z V C
    localparam logic [3:0] QIU_FLAGS_INS_LOCKFAIL = 4'h1;
    localparam logic [3:0] QIU_FLAGS_REM_LOCKFAIL = 4'h3;

    typedef enum logic [1:0] {
        QIU_K_TAIL = 2'b00,
        QIU_K_HEAD = 2'b01,
        QIU_K_PLAIN = 2'b10
    } qiu_kind_t;

    typedef enum logic [1:0] {
        QIU_O_OK = 2'b00,
        QIU_O_RSVOP = 2'b01,
        QIU_O_MMF = 2'b10,
        QIU_O_LOCKFAIL = 2'b11
    } qiu_outcome_t;

    typedef enum logic [2:0] {
        QIU_S_IDLE = 3'b000,
        QIU_S_LRD = 3'b001,
        QIU_S_LWB = 3'b010,
        QIU_S_RD2 = 3'b011,
        QIU_S_PRB = 3'b100,
        QIU_S_WR = 3'b101,
        QIU_S_REL = 3'b110,
        QIU_S_FIN = 3'b111
    } qiu_state_t;

endpackage : qiu_pkg

// *** qiu_queue_unit.sv ***
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module qiu_queue_unit
    import qiu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shared memory master
    output logic memReq,
    output logic memWrite,
    output logic memProbe,
    output logic memLock,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic [31:0] memRdata,
    // processor side
    output logic intHold,
    output logic irq
);

    qiu_state_t state_r;
    qiu_kind_t kind_r;
    qiu_outcome_t pend_r;
    logic [2:0] step_r;
    logic [31:0] opA_r, opB_r, tmp_r, rd2_r, result_r;
    logic [3:0] flags_r;
    logic [QIU_IRQ_W-1:0] irqStat_r, irqMask_r;
    logic [7:0] opcode_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic memReq_r, memWrite_r, memProbe_r, memLock_r;
    logic [31:0] memAddr_r, memWdata_r;
    logic irq_r;
    logic intHold_r;

    // apb decode
    wire setupPhase = psel && !penable;
    wire accessPhase = psel && penable && pready_r;
    wire wrStrobe = accessPhase && pwrite;
    wire hitCtrl = paddr == QIU_CTRL_OFF;
    wire hitOpA = paddr == QIU_OPA_OFF;
    wire hitOpB = paddr == QIU_OPB_OFF;
    wire hitStatus = paddr == QIU_STATUS_OFF;
    wire hitIrqStat = paddr == QIU_IRQ_STAT_OFF;
    wire hitIrqMask = paddr == QIU_IRQ_MASK_OFF;
    wire hitResult = paddr == QIU_RESULT_OFF;
    wire mapped = hitCtrl | hitOpA | hitOpB | hitStatus | hitIrqStat | hitIrqMask | hitResult;
    wire busy = state_r != QIU_S_IDLE;
    wire startPulse = wrStrobe && hitCtrl && pwdata[QIU_CTRL_START_BIT] && !busy;
    wire opWrite = wrStrobe && !busy;
    wire [7:0] newOpcode = pwdata[QIU_CTRL_OPC_LSB +: 8];

    logic [31:0] rdMux;
    always_comb begin
        rdMux = QIU_ZERO_WORD;
        if (hitCtrl) rdMux[QIU_CTRL_OPC_LSB +: 8] = opcode_r;
        if (hitOpA) rdMux = opA_r;
        if (hitOpB) rdMux = opB_r;
        if (hitStatus) begin
            rdMux[3:0] = flags_r;
            rdMux[QIU_STATUS_BUSY_BIT] = busy;
        end
        if (hitIrqStat) rdMux[QIU_IRQ_W-1:0] = irqStat_r;
        if (hitIrqMask) rdMux[QIU_IRQ_W-1:0] = irqMask_r;
        if (hitResult) rdMux = result_r;
    end

    // operand roles per instruction
    wire isTailOpc = newOpcode == QIU_OPC_INSERT_TAIL_LOCKED;
    wire isHeadOpc = newOpcode == QIU_OPC_REMOVE_HEAD_LOCKED;
    wire isPlainOpc = newOpcode == QIU_OPC_INSERT_AFTER_PRED;
    wire tailBadOps = (opA_r[2:0] != 3'h0) || (opB_r[2:0] != 3'h0) || (opA_r == opB_r);
    wire headBadOps = (opA_r[2:0] != 3'h0) || (opA_r == opB_r);
    wire [31:0] hdrAddr = (kind_r == QIU_K_HEAD) ? opA_r : opB_r;
    wire [31:0] tailAddr = opB_r + rd2_r;
    wire [31:0] remAddr = opA_r + tmp_r;
    wire [31:0] succAddr = remAddr + rd2_r;
    wire [31:0] newHead = tmp_r + rd2_r;
    wire queueWasEmpty = tmp_r == QIU_ZERO_WORD;
    wire tailWasEmpty = rd2_r == QIU_ZERO_WORD;

    // validation accesses, done before any link is touched
    logic [31:0] prbAddr;
    logic [2:0] prbCnt;
    always_comb begin
        prbAddr = opA_r;
        prbCnt = 3'h3;
        case (kind_r)
            QIU_K_TAIL: begin
                case (step_r)
                    3'h0: prbAddr = opA_r;
                    3'h1: prbAddr = opA_r + QIU_BACK_LINK_OFF;
                    default: prbAddr = tailAddr;
                endcase
            end
            QIU_K_HEAD: begin
                prbCnt = queueWasEmpty ? 3'h1 : 3'h2;
                prbAddr = (step_r == 3'h0) ? opB_r : succAddr + QIU_BACK_LINK_OFF;
            end
            default: begin
                prbCnt = 3'h4;
                case (step_r)
                    3'h0: prbAddr = opA_r;
                    3'h1: prbAddr = opA_r + QIU_BACK_LINK_OFF;
                    3'h2: prbAddr = opB_r;
                    default: prbAddr = rd2_r + QIU_BACK_LINK_OFF;
                endcase
            end
        endcase
    end

    // link update writes
    logic [31:0] wrAddr, wrData;
    logic [2:0] wrCnt;
    logic wrSkip;
    always_comb begin
        wrAddr = opA_r;
        wrData = QIU_ZERO_WORD;
        wrCnt = 3'h5;
        wrSkip = 1'b0;
        case (kind_r)
            QIU_K_TAIL: begin
                case (step_r)
                    3'h0: begin
                        wrAddr = opA_r;
                        wrData = opB_r - opA_r;
                    end
                    3'h1: begin
                        wrAddr = opA_r + QIU_BACK_LINK_OFF;
                        wrData = tailAddr - opA_r;
                    end
                    3'h2: begin
                        wrAddr = tailAddr;
                        wrData = opA_r - tailAddr;
                        wrSkip = tailWasEmpty;
                    end
                    3'h3: begin
                        wrAddr = opB_r + QIU_BACK_LINK_OFF;
                        wrData = opA_r - opB_r;
                    end
                    default: begin
                        wrAddr = opB_r;
                        wrData = tailWasEmpty ? opA_r - opB_r : tmp_r;
                    end
                endcase
            end
            QIU_K_HEAD: begin
                wrCnt = 3'h3;
                case (step_r)
                    3'h0: begin
                        wrAddr = opB_r;
                        wrData = remAddr;
                    end
                    3'h1: begin
                        wrAddr = succAddr + QIU_BACK_LINK_OFF;
                        wrData = opA_r - succAddr;
                        wrSkip = queueWasEmpty;
                    end
                    default: begin
                        wrAddr = opA_r;
                        wrData = newHead;
                    end
                endcase
            end
            default: begin
                wrCnt = 3'h4;
                case (step_r)
                    3'h0: begin
                        wrAddr = opA_r;
                        wrData = rd2_r;
                    end
                    3'h1: begin
                        wrAddr = opA_r + QIU_BACK_LINK_OFF;
                        wrData = opB_r;
                    end
                    3'h2: begin
                        wrAddr = rd2_r + QIU_BACK_LINK_OFF;
                        wrData = opA_r;
                    end
                    default: begin
                        wrAddr = opB_r;
                        wrData = opA_r;
                    end
                endcase
            end
        endcase
    end

    // final condition flags
    logic [3:0] okFlags;
    always_comb begin
        case (kind_r)
            QIU_K_TAIL: okFlags = {1'b0, tailWasEmpty, 2'b00};
            QIU_K_HEAD: okFlags = {1'b0, newHead == QIU_ZERO_WORD, queueWasEmpty, 1'b0};
            default: okFlags = {$signed(rd2_r) < $signed(opB_r), rd2_r == opB_r, 1'b0, rd2_r < opB_r};
        endcase
    end

    wire ackOk = memReq_r && memAck && !memErr;
    wire ackBad = memReq_r && memAck && memErr;
    wire lastPrb = step_r == prbCnt - 3'h1;
    wire lastWr = step_r == wrCnt - 3'h1;
    wire needReq = !memReq_r && (state_r != QIU_S_IDLE) && (state_r != QIU_S_FIN)
        && !(state_r == QIU_S_WR && wrSkip);

    // memory request issue, one access per state step, none for a skipped write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            memReq_r <= 1'b0;
            memWrite_r <= 1'b0;
            memProbe_r <= 1'b0;
            memAddr_r <= QIU_WORD_RST;
            memWdata_r <= QIU_WORD_RST;
        end else if (memReq_r) begin
            memReq_r <= !memAck;
        end else if (needReq) begin
            memReq_r <= 1'b1;
            memWrite_r <= state_r != QIU_S_LRD && state_r != QIU_S_RD2;
            memProbe_r <= state_r == QIU_S_PRB;
            case (state_r)
                QIU_S_LRD: memAddr_r <= hdrAddr;
                QIU_S_LWB: memAddr_r <= hdrAddr;
                QIU_S_REL: memAddr_r <= hdrAddr;
                QIU_S_RD2: memAddr_r <= (kind_r == QIU_K_TAIL) ? opB_r + QIU_BACK_LINK_OFF
                    : (kind_r == QIU_K_HEAD) ? remAddr : opB_r;
                QIU_S_PRB: memAddr_r <= prbAddr;
                default: memAddr_r <= wrAddr;
            endcase
            case (state_r)
                QIU_S_LWB: memWdata_r <= (pend_r == QIU_O_OK) ? (tmp_r | QIU_LOCK_MASK) : tmp_r;
                QIU_S_REL: memWdata_r <= tmp_r;
                default: memWdata_r <= wrData;
            endcase
        end
    end

    // instruction sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= QIU_S_IDLE;
            kind_r <= QIU_K_TAIL;
            pend_r <= QIU_O_OK;
            step_r <= QIU_STEP_RST;
            tmp_r <= QIU_WORD_RST;
            rd2_r <= QIU_WORD_RST;
            memLock_r <= 1'b0;
        end else begin
            case (state_r)
                QIU_S_IDLE: begin
                    if (startPulse) begin
                        step_r <= QIU_STEP_RST;
                        tmp_r <= QIU_WORD_RST;
                        rd2_r <= QIU_WORD_RST;
                        pend_r <= QIU_O_OK;
                        kind_r <= isHeadOpc ? QIU_K_HEAD : isTailOpc ? QIU_K_TAIL : QIU_K_PLAIN;
                        if ((isTailOpc && tailBadOps) || (isHeadOpc && headBadOps)
                            || !(isTailOpc || isHeadOpc || isPlainOpc)) begin
                            pend_r <= QIU_O_RSVOP;
                            state_r <= QIU_S_FIN;
                        end else if (isPlainOpc) begin
                            state_r <= QIU_S_RD2;
                        end else begin
                            memLock_r <= 1'b1;
                            state_r <= QIU_S_LRD;
                        end
                    end
                end
                QIU_S_LRD: begin
                    if (ackBad) begin
                        memLock_r <= 1'b0;
                        pend_r <= QIU_O_MMF;
                        state_r <= QIU_S_FIN;
                    end else if (ackOk) begin
                        tmp_r <= memRdata & ~QIU_LOCK_MASK;
                        if (memRdata[2:1] != 2'b00) pend_r <= QIU_O_RSVOP;
                        else if (memRdata[0]) pend_r <= QIU_O_LOCKFAIL;
                        if (memRdata[0]) tmp_r <= memRdata;
                        state_r <= QIU_S_LWB;
                    end
                end
                QIU_S_LWB: begin
                    if (memReq_r && memAck) begin
                        memLock_r <= 1'b0;
                        if (pend_r != QIU_O_OK) state_r <= QIU_S_FIN;
                        else if (kind_r == QIU_K_HEAD && queueWasEmpty) state_r <= QIU_S_PRB;
                        else state_r <= QIU_S_RD2;
                    end
                end
                QIU_S_RD2: begin
                    if (ackBad) begin
                        pend_r <= QIU_O_MMF;
                        state_r <= (kind_r == QIU_K_PLAIN) ? QIU_S_FIN : QIU_S_REL;
                    end else if (ackOk) begin
                        rd2_r <= memRdata;
                        if (kind_r == QIU_K_TAIL && (opB_r[2:0] + memRdata[2:0]) != 3'h0) begin
                            pend_r <= QIU_O_RSVOP;
                            state_r <= QIU_S_REL;
                        end else begin
                            state_r <= QIU_S_PRB;
                        end
                    end
                end
                QIU_S_PRB: begin
                    if (ackBad) begin
                        pend_r <= QIU_O_MMF;
                        state_r <= (kind_r == QIU_K_PLAIN) ? QIU_S_FIN : QIU_S_REL;
                    end else if (ackOk) begin
                        step_r <= lastPrb ? QIU_STEP_RST : step_r + 3'h1;
                        if (lastPrb) state_r <= QIU_S_WR;
                    end
                end
                QIU_S_WR: begin
                    if ((memReq_r && memAck) || (!memReq_r && wrSkip)) begin
                        step_r <= step_r + 3'h1;
                        if (lastWr) state_r <= QIU_S_FIN;
                    end
                end
                QIU_S_REL: begin
                    if (memReq_r && memAck) state_r <= QIU_S_FIN;
                end
                default: begin
                    state_r <= QIU_S_IDLE;
                end
            endcase
        end
    end

    // software registers, flags, interrupts
    wire [QIU_IRQ_W-1:0] irqSet = (state_r == QIU_S_FIN) ? {
        pend_r == QIU_O_MMF, pend_r == QIU_O_RSVOP, 1'b1} : QIU_IRQ_RST;
    wire [QIU_IRQ_W-1:0] irqClr = (wrStrobe && hitIrqStat) ? pwdata[QIU_IRQ_W-1:0] : QIU_IRQ_RST;
    wire [QIU_IRQ_W-1:0] irqStatNxt = (irqStat_r & ~irqClr) | irqSet;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            opA_r <= QIU_WORD_RST;
            opB_r <= QIU_WORD_RST;
            opcode_r <= 8'h00;
            irqMask_r <= QIU_IRQ_RST;
            irqStat_r <= QIU_IRQ_RST;
            irq_r <= 1'b0;
            intHold_r <= 1'b0;
        end else begin
            if (opWrite && hitOpA) opA_r <= pwdata;
            if (opWrite && hitOpB) opB_r <= pwdata;
            if (opWrite && hitCtrl) opcode_r <= newOpcode;
            if (wrStrobe && hitIrqMask) irqMask_r <= pwdata[QIU_IRQ_W-1:0];
            irqStat_r <= irqStatNxt;
            irq_r <= |(irqStatNxt & irqMask_r);
            // next-cycle busy, so the hold pin comes from a flop with no lag
            intHold_r <= startPulse || (busy && state_r != QIU_S_FIN);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= QIU_FLAGS_RST;
            result_r <= QIU_WORD_RST;
        end else if (state_r == QIU_S_FIN) begin
            if (pend_r == QIU_O_OK) flags_r <= okFlags;
            if (pend_r == QIU_O_LOCKFAIL) begin
                flags_r <= (kind_r == QIU_K_HEAD) ? QIU_FLAGS_REM_LOCKFAIL : QIU_FLAGS_INS_LOCKFAIL;
            end
            if (pend_r == QIU_O_OK && kind_r == QIU_K_HEAD) result_r <= remAddr;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= QIU_WORD_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setupPhase;
            pslverr_r <= setupPhase && !mapped;
            if (setupPhase) prdata_r <= pwrite ? QIU_ZERO_WORD : rdMux;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign memReq = memReq_r;
    assign memWrite = memWrite_r;
    assign memProbe = memProbe_r;
    assign memLock = memLock_r;
    assign memAddr = memAddr_r;
    assign memWdata = memWdata_r;
    assign intHold = intHold_r;
    assign irq = irq_r;

endmodule : qiu_queue_unit
`default_nettype wire

// *** qiu_queue_unit_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module qiu_queue_unit_chk
    import qiu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // memory
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memProbe,
    input wire logic memLock,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic [31:0] memRdata,
    // processor
    input wire logic intHold,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
        else $error("memory request changed before ack");
    req_gap_a: assert property (memReq && memAck |=> !memReq)
        else $error("no idle cycle after ack");
    lock_read_a: assert property ($rose(memLock) |=> memReq && !memWrite)
        else $error("lock did not start with a read");
    lock_drop_a: assert property (memLock && memReq && memWrite && memAck |=> !memLock)
        else $error("lock held after write-back");
    probe_write_a: assert property (memProbe && memReq |-> memWrite)
        else $error("probe without write direction");
    busy_req_a: assert property (memReq |-> intHold)
        else $error("memory access outside instruction");
endmodule : qiu_queue_unit_chk
`default_nettype wire

// *** queue_instruction_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module queue_instruction_unit_tb;
    import qiu_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, faultAddr = 32'hffff_fff0, rd, irqv;
    logic [31:0] prdata, memAddr, memWdata, memRdata;
    logic pready, pslverr, memReq, memWrite, memProbe, memLock, memAck, memErr, intHold, irq, er;
    logic [2:0] msk = 3'h0;
    int bad_count = 0, n_checks = 0, cyc = 0;

    always #50 core_clk = ~core_clk;

    qiu_queue_unit qiu_queue_unit_i(.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .memReq, .memWrite, .memProbe, .memLock, .memAddr, .memWdata, .memAck, .memErr,
        .memRdata, .intHold, .irq);
    qiu_mem_model qiu_mem_model_i(.core_clk, .resetn, .memReq, .memWrite, .memProbe, .memLock, .memAddr,
        .memWdata, .memAck, .memErr, .memRdata, .slow, .faultAddr);

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task mset(input logic [31:0] a, input logic [31:0] v);
        qiu_mem_model_i.mem[a[8:2]] = v;
    endtask : mset

    task mchk(input logic [31:0] a, input logic [31:0] e);
        chk("memory word", e, qiu_mem_model_i.mem[a[8:2]]);
    endtask : mchk

    // start one instruction, wait for idle, check irq bit and, on a done run, flags
    task run(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b, input int bi,
        input logic [3:0] f);
        int k;
        apb(1'b1, QIU_OPA_OFF, a);
        apb(1'b1, QIU_OPB_OFF, b);
        apb(1'b1, QIU_CTRL_OFF, {16'h0, opc, 8'h01});
        @(negedge core_clk);
        chk("hold busy", 32'h1, {31'h0, intHold});
        k = 0;
        do begin
            apb(1'b0, QIU_STATUS_OFF, 32'h0);
            k++;
        end while (rd[QIU_STATUS_BUSY_BIT] !== 1'b0 && k < 300);
        chk("hold idle", 32'h0, {31'h0, intHold});
        if (bi == QIU_IRQ_DONE_BIT) chk("flags", {28'h0, f}, {28'h0, rd[3:0]});
        apb(1'b0, QIU_IRQ_STAT_OFF, 32'h0);
        irqv = rd;
        chk("irq status bit", 32'h1, {31'h0, irqv[bi]});
        chk("irq pin", {31'h0, |(irqv[2:0] & msk)}, {31'h0, irq});
        apb(1'b1, QIU_IRQ_STAT_OFF, 32'h7);
        repeat (3) @(posedge core_clk);
        chk("irq pin cleared", 32'h0, {31'h0, irq});
    endtask : run

    task t_regs;
        apb(1'b0, QIU_STATUS_OFF, 32'h0);
        chk("status reset", 32'h0, rd);
        apb(1'b0, QIU_IRQ_STAT_OFF, 32'h0);
        chk("irq reset", 32'h0, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
    endtask : t_regs

    task t_tail;
        mset(32'h40, 32'h0);
        mset(32'h44, 32'h0);
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'h80, 32'h40, QIU_IRQ_DONE_BIT, 4'h4);
        mchk(32'h80, 32'hffff_ffc0);
        mchk(32'h84, 32'hffff_ffc0);
        mchk(32'h40, 32'h40);
        mchk(32'h44, 32'h40);
        slow <= 1'b1;
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'ha0, 32'h40, QIU_IRQ_DONE_BIT, 4'h0);
        mchk(32'ha0, 32'hffff_ffa0);
        mchk(32'ha4, 32'hffff_ffe0);
        mchk(32'h80, 32'h20);
        mchk(32'h44, 32'h60);
        mchk(32'h40, 32'h40);
        slow <= 1'b0;
    endtask : t_tail

    task t_remove;
        run(QIU_OPC_REMOVE_HEAD_LOCKED, 32'h40, 32'hc0, QIU_IRQ_DONE_BIT, 4'h0);
        mchk(32'hc0, 32'h80);
        mchk(32'ha4, 32'hffff_ffa0);
        mchk(32'h40, 32'h60);
        apb(1'b0, QIU_RESULT_OFF, 32'h0);
        chk("result", 32'h80, rd);
        mset(32'h180, 32'h0);
        mset(32'h184, 32'h0);
        run(QIU_OPC_REMOVE_HEAD_LOCKED, 32'h180, 32'h1c0, QIU_IRQ_DONE_BIT, 4'h6);
        mchk(32'h180, 32'h0);
    endtask : t_remove

    task t_lockfail;
        msk = 3'h1;
        apb(1'b1, QIU_IRQ_MASK_OFF, 32'h1);
        mset(32'h40, 32'h61);
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'he0, 32'h40, QIU_IRQ_DONE_BIT, QIU_FLAGS_INS_LOCKFAIL);
        mchk(32'h40, 32'h61);
        mset(32'hc8, 32'h0);
        run(QIU_OPC_REMOVE_HEAD_LOCKED, 32'h40, 32'hc8, QIU_IRQ_DONE_BIT, QIU_FLAGS_REM_LOCKFAIL);
        mchk(32'h40, 32'h61);
        mchk(32'hc8, 32'h0);
        mset(32'h40, 32'h60);
        msk = 3'h0;
        apb(1'b1, QIU_IRQ_MASK_OFF, 32'h0);
    endtask : t_lockfail

    task t_faults;
        faultAddr <= 32'h100;
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'h100, 32'h40, QIU_IRQ_MMF_BIT, 4'h0);
        mchk(32'h40, 32'h60);
        mchk(32'h44, 32'h60);
        faultAddr <= 32'hffff_fff0;
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'h84, 32'h40, QIU_IRQ_RSVOP_BIT, 4'h0);
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'h40, 32'h40, QIU_IRQ_RSVOP_BIT, 4'h0);
        mchk(32'h40, 32'h60);
        run(QIU_OPC_REMOVE_HEAD_LOCKED, 32'h40, 32'h40, QIU_IRQ_RSVOP_BIT, 4'h0);
        mset(32'h40, 32'h62);
        run(QIU_OPC_INSERT_TAIL_LOCKED, 32'h100, 32'h40, QIU_IRQ_RSVOP_BIT, 4'h0);
        mchk(32'h40, 32'h62);
    endtask : t_faults

    task t_plain;
        mset(32'h120, 32'h100);
        run(QIU_OPC_INSERT_AFTER_PRED, 32'h140, 32'h120, QIU_IRQ_DONE_BIT, 4'h9);
        mchk(32'h140, 32'h100);
        mchk(32'h144, 32'h120);
        mchk(32'h104, 32'h140);
        mchk(32'h120, 32'h140);
    endtask : t_plain

    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_tail();
        t_remove();
        t_lockfail();
        t_faults();
        t_plain();
        end_sim();
    end
endmodule : queue_instruction_unit_tb

bind qiu_queue_unit qiu_queue_unit_chk qiu_queue_unit_chk_i(.core_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .memReq, .memWrite, .memProbe, .memLock, .memAddr,
    .memWdata, .memAck, .memErr, .memRdata, .intHold, .irq);
`default_nettype wire
